//--- ndr_pkg.sv
package ndr_pkg;

   // ***********************************************
   // clock and conversion helpers
   // ***********************************************
   localparam int CLK_PS = 5000;

   // least time in ns to whole cycles, rounded up, at least one
   function automatic int cycMin(input int ns);
      int c;
      c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   // longest time in ns to whole cycles, rounded down, at least one
   function automatic int cycMax(input int ns);
      int c;
      c = (ns * 1000) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int imax(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   // ***********************************************
   // power-up and refresh figures
   // ***********************************************
   localparam int PAUSE_US = 200;
   localparam int PAUSE_CYC_DEF = cycMin(PAUSE_US * 1000);
   localparam logic [3:0] INIT_CBR_COUNT = 4'h8;
   localparam int REF_ROWS = 512;
   localparam int REF_PERIOD_NS = 8200000;
   localparam int REF_INT_CYC = cycMax(REF_PERIOD_NS / REF_ROWS);

   // ***********************************************
   // strobe timing in ns and derived cycle counts
   // ***********************************************
   localparam int RAS_MAX_NS = 100000;
   localparam int RAS_MAX_CYC_DEF = cycMax(RAS_MAX_NS);
   localparam int RAS_MIN_CYC = cycMin(70);
   localparam int RP_CYC = cycMin(45);
   localparam int RAH_CYC = cycMin(10);
   localparam int RCD_CYC = cycMin(20);
   localparam int ROW_ACCESS_NS = 100;
   localparam int RD_CAS_CYC = imax(cycMin(ROW_ACCESS_NS) - RCD_CYC, 1);
   localparam int CSR_CYC = cycMin(0);
   localparam int CHR_CYC = cycMin(10);
   localparam int CWD_CYC = cycMin(20);
   localparam int AWD_CYC = cycMin(35);
   localparam int RWD_CYC = cycMin(70);
   localparam int RMW_WE_CYC =
      imax(imax(RWD_CYC - RCD_CYC, CWD_CYC), AWD_CYC - (RCD_CYC - RAH_CYC)) + 1;
   localparam int CWL_CYC = cycMin(12);
   localparam int RWL_CYC = cycMin(15);
   localparam int NC_CYC = cycMin(40);
   localparam int NRWC_CYC = cycMin(60);
   localparam int NCP_CYC = cycMin(10);
   localparam int NPA_CYC = cycMax(35);
   localparam int NIB_LOW_CYC = imax(NC_CYC - NCP_CYC, NPA_CYC - NCP_CYC + 1);
   localparam int FCAC_CYC = cycMin(45);
   localparam int FCWD_CYC = imax(cycMin(45), FCAC_CYC);
   localparam int CPT_CYC = cycMin(20);

   // ***********************************************
   // user commands and sequencer states
   // ***********************************************
   typedef enum logic [2:0] {
      CMD_READ = 3'h0,
      CMD_WRITE = 3'h1,
      CMD_RMW = 3'h2,
      CMD_NIB_READ = 3'h3,
      CMD_NIB_WRITE = 3'h4,
      CMD_CTEST = 3'h5
   } ndr_cmd_t;

   typedef enum logic [11:0] {
      ST_PAUSE = 12'h001,
      ST_IDLE = 12'h002,
      ST_CBR_CAS = 12'h004,
      ST_CBR_RAS = 12'h008,
      ST_ROW = 12'h010,
      ST_COL = 12'h020,
      ST_WE = 12'h040,
      ST_NIB_PRE = 12'h080,
      ST_CT_PRE = 12'h100,
      ST_CT_COL = 12'h200,
      ST_RAS_END = 12'h400,
      ST_PRECH = 12'h800
   } ndr_state_t;

endpackage

//--- ndr_ref_if.sv
// pause and refresh handshake between timer and sequencer
interface ndr_ref_if;
   logic pauseDone;
   logic refReq;
   logic refAck;
   modport timer(output pauseDone, output refReq, input refAck);
   modport ctrl(input pauseDone, input refReq, output refAck);
endinterface

//--- ndr_refresh_timer.sv
module ndr_refresh_timer #(
   parameter int PAUSE_CYC = ndr_pkg::PAUSE_CYC_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // handshake to sequencer
   ndr_ref_if.timer rif
);
   import ndr_pkg::*;

   int pause_q;
   int tick_q;
   logic pauseDone_q;
   logic refReq_q;

   // ***********************************************
   // power-up pause, strobes idle meanwhile
   // ***********************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         pause_q <= 0;
         pauseDone_q <= 1'h0;
      end else if (!pauseDone_q) begin
         pause_q <= pause_q + 1;
         if (pause_q >= PAUSE_CYC - 1) begin
            pauseDone_q <= 1'h1;
         end
      end
   end

   // ***********************************************
   // refresh interval ticker and pending request
   // ***********************************************
   // evenly spaced ticks over the refresh period
   always_ff @(posedge clk) begin
      if (rst || !pauseDone_q) begin
         tick_q <= 0;
      end else if (tick_q >= REF_INT_CYC - 1) begin
         tick_q <= 0;
      end else begin
         tick_q <= tick_q + 1;
      end
   end

   // a tick in the ack cycle keeps the request
   always_ff @(posedge clk) begin
      if (rst) begin
         refReq_q <= 1'h0;
      end else if (pauseDone_q && tick_q >= REF_INT_CYC - 1) begin
         refReq_q <= 1'h1;
      end else if (rif.refAck) begin
         refReq_q <= 1'h0;
      end
   end

   assign rif.pauseDone = pauseDone_q;
   assign rif.refReq = refReq_q;

endmodule

//--- ndr_dram_ctrl.sv
// Notes on behaviour
// - after power-up keep both strobes high 200 us, then eight init cycles.
// - using the internal counter, initialise with eight column-before-row refreshes.
// - a read keeps the write strobe high until the column strobe rises.
// - never mix single read, write or read-modify-write with nibble mode.
// - refresh all 512 rows within every 8.2 ms.
// - hold column strobe low at least 10 ns after row strobe falls.
// - in refresh the column strobe may fall right after row precharge.
// - nibble cycles last at least 40 ns with 10 ns column precharge.
// - a nibble read-modify-write cycle lasts at least 60 ns.
// - counter test procedure is run by the user through counter test commands.
// - counter test data within 45 ns; keep write delay and 20 ns precharge.
// - row strobe low at least 70 ns and at most 100000 ns.
// - row strobe high at least 45 ns between cycles.
module ndr_dram_ctrl #(
   parameter int PAUSE_CYC = ndr_pkg::PAUSE_CYC_DEF,
   parameter int RAS_MAX_CYC = ndr_pkg::RAS_MAX_CYC_DEF
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // user request
   input wire logic reqValid,
   output logic reqReady,
   input wire ndr_pkg::ndr_cmd_t reqCmd,
   input wire logic [19:0] reqAddr,
   input wire logic [3:0] reqWdata,
   // user answer
   output logic rspValid,
   output logic [3:0] rspData,
   output logic initDone,
   // memory pins
   output logic rowStrobeN,
   output logic columnStrobeN,
   output logic writeStrobeN,
   output logic [9:0] addressLines,
   output logic dataInPin,
   input wire logic dataOutPin
);
   import ndr_pkg::*;

   ndr_state_t state_q;
   ndr_cmd_t cmd_q;
   int el_q;
   int rasLow_q;
   int rasHigh_q;
   int refWait_q;
   logic [19:0] addrReq_q;
   logic [3:0] wdata_q;
   logic [3:0] rdBuf_q;
   logic [1:0] nib_q;
   logic [3:0] initLeft_q;
   logic ctest_q;
   logic rasN_q;
   logic casN_q;
   logic weN_q;
   logic [9:0] addr_q;
   logic dq_q;
   logic rspValid_q;
   logic refAck_q;

   ndr_ref_if rif();

   ndr_refresh_timer #(.PAUSE_CYC(PAUSE_CYC)) uTimer (
      .clk(clk),
      .rst(rst),
      .rif(rif)
   );

   // ***********************************************
   // command decoding helpers
   // ***********************************************
   function automatic logic isWr(input ndr_cmd_t c);
      return (c == CMD_WRITE) || (c == CMD_NIB_WRITE);
   endfunction

   function automatic logic isNib(input ndr_cmd_t c);
      return (c == CMD_NIB_READ) || (c == CMD_NIB_WRITE);
   endfunction

   // cycles elapsed in the current state reach n
   function automatic logic done(input int n);
      return el_q >= n - 1;
   endfunction

   // ***********************************************
   // strobe sequencer
   // ***********************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_PAUSE;
         el_q <= 0;
         cmd_q <= CMD_READ;
         addrReq_q <= 20'h00000;
         wdata_q <= 4'h0;
         rdBuf_q <= 4'h0;
         nib_q <= 2'h0;
         initLeft_q <= INIT_CBR_COUNT;
         ctest_q <= 1'h0;
         rasN_q <= 1'h1;
         casN_q <= 1'h1;
         weN_q <= 1'h1;
         addr_q <= 10'h000;
         dq_q <= 1'h0;
         rspValid_q <= 1'h0;
         refAck_q <= 1'h0;
      end else begin
         el_q <= el_q + 1;
         rspValid_q <= 1'h0;
         refAck_q <= 1'h0;
         case (state_q)
            ST_PAUSE: begin
               if (rif.pauseDone) begin
                  state_q <= ST_IDLE;
                  el_q <= 0;
               end
            end
            ST_IDLE: begin
               if (initLeft_q != 4'h0 || rif.refReq) begin
                  casN_q <= 1'h0;
                  ctest_q <= 1'h0;
                  state_q <= ST_CBR_CAS;
                  el_q <= 0;
               end else if (reqValid) begin
                  cmd_q <= reqCmd;
                  addrReq_q <= reqAddr;
                  wdata_q <= reqWdata;
                  nib_q <= 2'h0;
                  el_q <= 0;
                  if (reqCmd == CMD_CTEST) begin
                     casN_q <= 1'h0;
                     ctest_q <= 1'h1;
                     state_q <= ST_CBR_CAS;
                  end else begin
                     rasN_q <= 1'h0;
                     addr_q <= reqAddr[19:10];
                     state_q <= ST_ROW;
                  end
               end
            end
            ST_CBR_CAS: begin
               if (done(CSR_CYC)) begin
                  rasN_q <= 1'h0;
                  state_q <= ST_CBR_RAS;
                  el_q <= 0;
               end
            end
            ST_CBR_RAS: begin
               if (ctest_q && done(CHR_CYC)) begin
                  casN_q <= 1'h1;
                  addr_q <= addrReq_q[9:0];
                  state_q <= ST_CT_PRE;
                  el_q <= 0;
               end else if (!ctest_q) begin
                  if (done(CHR_CYC)) begin
                     casN_q <= 1'h1;
                  end
                  if (done(RAS_MIN_CYC)) begin
                     rasN_q <= 1'h1;
                     state_q <= ST_PRECH;
                     el_q <= 0;
                     if (initLeft_q != 4'h0) begin
                        initLeft_q <= initLeft_q - 4'h1;
                     end else begin
                        refAck_q <= 1'h1;
                     end
                  end
               end
            end
            ST_ROW: begin
               if (done(RAH_CYC)) begin
                  addr_q <= addrReq_q[9:0];
               end
               if (done(RCD_CYC)) begin
                  casN_q <= 1'h0;
                  weN_q <= !isWr(cmd_q);
                  dq_q <= wdata_q[0];
                  state_q <= ST_COL;
                  el_q <= 0;
               end
            end
            ST_COL: begin
               if (cmd_q == CMD_RMW) begin
                  if (done(RMW_WE_CYC)) begin
                     rdBuf_q[0] <= dataOutPin;
                     weN_q <= 1'h0;
                     dq_q <= wdata_q[0];
                     state_q <= ST_WE;
                     el_q <= 0;
                  end
               end else if (done((!isWr(cmd_q) && nib_q == 2'h0) ? RD_CAS_CYC : NIB_LOW_CYC)) begin
                  if (!isWr(cmd_q)) begin
                     rdBuf_q[nib_q] <= dataOutPin;
                  end
                  casN_q <= 1'h1;
                  el_q <= 0;
                  if (isNib(cmd_q) && nib_q != 2'h3) begin
                     nib_q <= nib_q + 2'h1;
                     state_q <= ST_NIB_PRE;
                  end else begin
                     state_q <= ST_RAS_END;
                  end
               end
            end
            ST_NIB_PRE: begin
               if (done(NCP_CYC)) begin
                  casN_q <= 1'h0;
                  dq_q <= wdata_q[nib_q];
                  state_q <= ST_COL;
                  el_q <= 0;
               end
            end
            ST_CT_PRE: begin
               if (done(CPT_CYC)) begin
                  casN_q <= 1'h0;
                  state_q <= ST_CT_COL;
                  el_q <= 0;
               end
            end
            ST_CT_COL: begin
               if (done(FCWD_CYC)) begin
                  rdBuf_q[0] <= dataOutPin;
                  weN_q <= 1'h0;
                  dq_q <= wdata_q[0];
                  state_q <= ST_WE;
                  el_q <= 0;
               end
            end
            ST_WE: begin
               if (done(CWL_CYC)) begin
                  casN_q <= 1'h1;
                  state_q <= ST_RAS_END;
                  el_q <= 0;
               end
            end
            ST_RAS_END: begin
               if (done(RWL_CYC) && rasLow_q >= RAS_MIN_CYC) begin
                  rasN_q <= 1'h1;
                  weN_q <= 1'h1;
                  rspValid_q <= 1'h1;
                  state_q <= ST_PRECH;
                  el_q <= 0;
               end
            end
            ST_PRECH: begin
               if (done(RP_CYC)) begin
                  state_q <= ST_IDLE;
                  el_q <= 0;
               end
            end
            default: begin
               rasN_q <= 1'h1;
               casN_q <= 1'h1;
               weN_q <= 1'h1;
               state_q <= ST_PRECH;
               el_q <= 0;
            end
         endcase
      end
   end

   // ***********************************************
   // strobe width and refresh wait counters
   // ***********************************************
   // cycles spent with the row strobe low
   always_ff @(posedge clk) begin
      if (rst || rasN_q) begin
         rasLow_q <= 0;
      end else begin
         rasLow_q <= rasLow_q + 1;
      end
   end

   // cycles of row precharge, saturating
   always_ff @(posedge clk) begin
      if (rst) begin
         rasHigh_q <= RP_CYC;
      end else if (!rasN_q) begin
         rasHigh_q <= 0;
      end else if (rasHigh_q < RP_CYC) begin
         rasHigh_q <= rasHigh_q + 1;
      end
   end

   // age of a pending refresh request
   always_ff @(posedge clk) begin
      if (rst || !rif.refReq) begin
         refWait_q <= 0;
      end else begin
         refWait_q <= refWait_q + 1;
      end
   end

   // ***********************************************
   // outputs
   // ***********************************************
   assign rif.refAck = refAck_q;
   assign reqReady = (state_q == ST_IDLE) && (initLeft_q == 4'h0) && !rif.refReq;
   assign initDone = (state_q != ST_PAUSE) && (initLeft_q == 4'h0);
   assign rspValid = rspValid_q;
   assign rspData = rdBuf_q;
   assign rowStrobeN = rasN_q;
   assign columnStrobeN = casN_q;
   assign writeStrobeN = weN_q;
   assign addressLines = addr_q;
   assign dataInPin = dq_q;

   // ***********************************************
   // checks
   // ***********************************************
   chk_pause_strobes_high: assert property (
      @(posedge clk) disable iff (rst) !rif.pauseDone |-> rasN_q && casN_q)
      else $error("strobe active during power-up pause");
   chk_init_before_access: assert property (
      @(posedge clk) disable iff (rst) $fell(casN_q) && !rasN_q |-> initLeft_q == 4'h0)
      else $error("access before initialisation refreshes");
   chk_read_we_high: assert property (
      @(posedge clk) disable iff (rst)
      !casN_q && (cmd_q == CMD_READ || cmd_q == CMD_NIB_READ) && state_q == ST_COL |-> weN_q)
      else $error("write strobe low during read");
   chk_refresh_served: assert property (
      @(posedge clk) disable iff (rst) refWait_q < REF_INT_CYC)
      else $error("refresh request waited a whole interval");
   chk_cbr_cas_hold: assert property (
      @(posedge clk) disable iff (rst) $fell(rasN_q) && !casN_q |-> !casN_q [*2])
      else $error("column strobe released too soon after refresh row fall");
   chk_nibble_precharge: assert property (
      @(posedge clk) disable iff (rst) $rose(casN_q) && !rasN_q |-> casN_q [*2])
      else $error("column precharge shorter than two cycles");
   chk_ctest_precharge: assert property (
      @(posedge clk) disable iff (rst) $rose(casN_q) && ctest_q && !rasN_q |-> casN_q [*4])
      else $error("counter test column precharge too short");
   chk_ras_width_min: assert property (
      @(posedge clk) disable iff (rst) $rose(rasN_q) |-> $past(rasLow_q) >= RAS_MIN_CYC - 1)
      else $error("row strobe pulse too short");
   chk_ras_width_max: assert property (
      @(posedge clk) disable iff (rst) rasLow_q < RAS_MAX_CYC)
      else $error("row strobe pulse too long");
   chk_precharge_min: assert property (
      @(posedge clk) disable iff (rst) $fell(rasN_q) |-> $past(rasHigh_q) >= RP_CYC)
      else $error("row precharge too short");

endmodule

//--- ndr_dram_model.sv
module ndr_dram_model #(
   parameter int CAC_NS = 19,
   parameter int NPA_NS = 34,
   parameter int FCAC_NS = 44
) (
   // strobes and address from controller
   input wire logic rowStrobeN,
   input wire logic columnStrobeN,
   input wire logic writeStrobeN,
   input wire logic [9:0] addressLines,
   input wire logic dataInPin,
   // data to controller
   output logic dataOutPin
);
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************************
   // cell array, refresh counter, timing log
   // ***************************************
   bit mem [int];
   logic [8:0] refCnt = 9'h000;
   logic [9:0] row = 10'h000;
   logic [9:0] col = 10'h000;
   logic cbr = 1'b0;
   logic ctest = 1'b0;
   logic rdCyc = 1'b0;
   int cbrCnt = 0;
   int rowCnt = 0;
   int viol = 0;
   int gen = 0;
   int nib = 0;
   realtime tR, tC;
   realtime rowFallT = 0;
   realtime rowRiseT = -1e6;
   realtime colFallT = 0;
   realtime colRiseT = -1e6;
   realtime firstRowT = -1;
   realtime lastCbrT = 0;
   realtime prevCbrT = 0;

   initial dataOutPin = 1'b0;

   // released output shows the inverse of its last value
   task automatic release_out();
      gen++;
      dataOutPin = ~dataOutPin;
   endtask

   // cell value after the access delay, unless a newer event cancels it
   task automatic drive_late(input int key, input realtime dly);
      int g;
      g = gen + 1;
      gen = g;
      fork
         begin
            #(dly);
            if (g == gen) dataOutPin = mem[key];
         end
      join_none
   endtask

   // row fall: pick refresh kind, latch row
   always @(negedge rowStrobeN) begin
      #1;
      tR = $realtime - 1;
      if (tR - rowRiseT < 45) viol++;
      if (firstRowT < 0) firstRowT = tR;
      rowFallT = tR;
      nib = 0;
      ctest = 1'b0;
      rdCyc = 1'b0;
      cbr = !columnStrobeN;
      if (cbr) begin
         row = {1'b0, refCnt};
         cbrCnt++;
         prevCbrT = lastCbrT;
         lastCbrT = tR;
      end else begin
         row = addressLines;
         rowCnt++;
      end
   end

   // row rise: pulse width, counter step
   always @(posedge rowStrobeN) begin
      rowRiseT = $realtime;
      // the first rise is the strobe leaving unknown at reset, with no pulse before it
      if (firstRowT >= 0 && (rowRiseT - rowFallT < 70 || rowRiseT - rowFallT > 100000)) begin
         viol++;
      end
      if (cbr) refCnt++;
      cbr = 1'b0;
      if (columnStrobeN) release_out();
   end

   // column fall: column latch, early write or read access
   always @(negedge columnStrobeN) begin
      #1;
      tC = $realtime - 1;
      if (!rowStrobeN) begin
         if ((nib > 0 || cbr) && tC - colRiseT < (cbr ? 20 : 10)) viol++;
         if (nib > 0 && tC - colFallT < 40) viol++;
         if (cbr) begin
            ctest = 1'b1;
            row = {1'b1, refCnt};
            col = addressLines;
         end else if (nib == 0) begin
            col = addressLines;
         end else begin
            col[1:0] = col[1:0] + 2'h1;
         end
         colFallT = tC;
         rdCyc = writeStrobeN;
         if (!writeStrobeN) begin
            mem[int'({row, col})] = dataInPin;
            release_out();
         end else if (ctest) begin
            drive_late(int'({row, col}), FCAC_NS - 1);
         end else begin
            drive_late(int'({row, col}), nib > 0 ? NPA_NS - (tC - colRiseT) : CAC_NS);
         end
      end
   end

   // column rise: hold after refresh, nibble step, output off
   always @(posedge columnStrobeN) begin
      if (!rowStrobeN) begin
         if (cbr && !ctest && $realtime - rowFallT < 10) viol++;
         if (!cbr) nib++;
         colRiseT = $realtime;
      end
      release_out();
   end

   // late write strobe: read-modify-write keeps data, else delayed write
   always @(negedge writeStrobeN) begin
      #1;
      if (!rowStrobeN && !columnStrobeN && rdCyc) begin
         mem[int'({row, col})] = dataInPin;
         rdCyc = 1'b0;
         if ($realtime - 1 - colFallT < (ctest ? 45 : 20)) release_out();
      end
   end
endmodule

//--- ndr_dram_ctrl_bench.sv
module ndr_dram_ctrl_bench;
   import ndr_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   // ***************************************
   // design, memory model, clock
   // ***************************************
   localparam int PCYC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reqValid = 1'b0;
   ndr_cmd_t reqCmd = CMD_READ;
   logic [19:0] reqAddr = 20'h00000;
   logic [3:0] reqWdata = 4'h0;
   logic reqReady, rspValid, initDone, rowStrobeN, columnStrobeN, writeStrobeN;
   logic dataInPin, dataOutPin;
   logic [3:0] rspData;
   logic [9:0] addressLines;
   logic [8:0] cntAtTake;
   logic [3:0] rd;
   realtime relT;
   int fail_count = 0;
   int n_checks = 0;

   ndr_dram_ctrl #(.PAUSE_CYC(PCYC)) dut (.clk(clk), .rst(rst), .reqValid(reqValid),
      .reqReady(reqReady), .reqCmd(reqCmd), .reqAddr(reqAddr), .reqWdata(reqWdata),
      .rspValid(rspValid), .rspData(rspData), .initDone(initDone), .rowStrobeN(rowStrobeN),
      .columnStrobeN(columnStrobeN), .writeStrobeN(writeStrobeN),
      .addressLines(addressLines), .dataInPin(dataInPin), .dataOutPin(dataOutPin));

   ndr_dram_model model (.rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN),
      .writeStrobeN(writeStrobeN), .addressLines(addressLines), .dataInPin(dataInPin),
      .dataOutPin(dataOutPin));

   always #2.5 clk = ~clk;

   // ***************************************
   // shared tasks
   // ***************************************
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one request: hold until taken, then wait for the answer pulse
   task automatic do_req(input ndr_cmd_t cmd, input logic [19:0] addr, input logic [3:0] wd,
                         output logic [3:0] data);
      int n;
      @(negedge clk);
      reqValid = 1'b1;
      reqCmd = cmd;
      reqAddr = addr;
      reqWdata = wd;
      n = 0;
      while (reqReady !== 1'b1 && n < 5000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 5000) fail_count++;
      @(negedge clk);
      cntAtTake = model.refCnt;
      reqValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) fail_count++;
      data = rspData;
   endtask

   // reset, pause and initialising refreshes
   task automatic t_reset();
      int n;
      repeat (10) @(negedge clk);
      check({rowStrobeN, columnStrobeN, writeStrobeN, reqReady, initDone}, 20'h0001C);
      rst = 1'b0;
      relT = $realtime;
      n = 0;
      while (initDone !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) fail_count++;
      check(20'(model.cbrCnt), 20'h00008);
      check(20'(model.rowCnt), 20'h00000);
      check(model.firstRowT - relT >= PCYC * 5, 1'b1);
      // init done rises with the last refresh, ready follows its precharge
      repeat (RP_CYC + 1) @(negedge clk);
      check(reqReady, 1'b1);
   endtask

   // back-to-back early writes, reads, read-modify-write
   task automatic t_single();
      do_req(CMD_WRITE, 20'h12345, 4'h1, rd);
      do_req(CMD_WRITE, 20'h12346, 4'h0, rd);
      check(model.mem[int'(20'h12345)], 1'b1);
      do_req(CMD_READ, 20'h12345, 4'h0, rd);
      check(rd[0], 1'b1);
      do_req(CMD_READ, 20'h12346, 4'h0, rd);
      check(rd[0], 1'b0);
      do_req(CMD_RMW, 20'h12345, 4'h0, rd);
      check(rd[0], 1'b1);
      check(model.mem[int'(20'h12345)], 1'b0);
   endtask

   // nibble write then nibble read, bit 0 first
   task automatic t_nibble();
      do_req(CMD_NIB_WRITE, 20'h0A0C4, 4'hA, rd);
      for (int i = 0; i < 4; i++) begin
         check(model.mem[32'h0A0C4 + i], 1'(4'hA >> i));
      end
      do_req(CMD_NIB_READ, 20'h0A0C4, 4'h0, rd);
      check(rd, 4'hA);
   endtask

   // two counter test cycles on seeded cells
   task automatic t_ctest();
      for (int r = 512; r < 1024; r++) begin
         model.mem[r * 1024 + 7] = 1'b1;
      end
      repeat (2) begin
         do_req(CMD_CTEST, 20'h00007, 4'h0, rd);
         check(rd[0], 1'b1);
         check(model.row, {1'b1, cntAtTake});
         check(model.col, 10'h007);
         check(model.refCnt, cntAtTake + 9'h001);
         check(model.mem[int'({1'b1, cntAtTake, 10'h007})], 1'b0);
      end
   endtask

   // spacing of periodic refreshes while idle
   task automatic t_refresh();
      int n;
      int k;
      n = model.cbrCnt;
      k = 0;
      while (model.cbrCnt < n + 2 && k < 8000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 8000) fail_count++;
      check(model.lastCbrT - model.prevCbrT <= REF_INT_CYC * 5, 1'b1);
      check(model.lastCbrT - model.prevCbrT >= (REF_INT_CYC - 2) * 5, 1'b1);
   endtask

   // ***************************************
   // main sequence and watchdog
   // ***************************************
   initial begin
      t_reset();
      t_single();
      t_nibble();
      t_ctest();
      t_refresh();
      check(20'(model.viol), 20'h00000);
      report_and_stop();
   end

   initial begin
      #200us;
      fail_count++;
      report_and_stop();
   end
endmodule
